// ---- shared/touch_seq_map.vh ----
`ifndef TOUCH_SEQ_MAP_VH
`define TOUCH_SEQ_MAP_VH

// register byte offsets
`define REG_SAMPLE 4'h0
`define REG_CTRL_BYTE 4'h4
`define REG_STATUS 4'h8
`define REG_CONV_COUNT 4'hC

// control byte field positions
`define CB_START 7
`define CB_CHAN_HI 6
`define CB_CHAN_LO 4
`define CB_MODE 3
`define CB_SER 2
`define CB_PD1 1
`define CB_PD0 0

// status field positions
`define ST_BUSY 0
`define ST_MEASURING 1
`define ST_PEN_ENABLED 2
`define ST_ADC_POWERED 3
`define ST_REF_POWERED 4
`define ST_Y_LOW 5
`define ST_PEN_IRQ_N 6
`define ST_DROOP 7
`define ST_RX_ACTIVE 8
`define ST_CS_N 9

// reset values
`define SAMPLE_RESET 12'h000
`define CTRL_BYTE_RESET 8'h00

// conversion lengths in falling edges of the bit clock
`define BITS_12 5'h0C
`define BITS_8 5'h08

// channel codes of the touch position measurements
`define CHAN_Y 3'h1
`define CHAN_Z1 3'h3
`define CHAN_Z2 3'h4
`define CHAN_X 3'h5

// sample-and-hold droop limit, 1.6 ms
`define DROOP_LIMIT_US 1600
`define CLK_PERIOD_NS 10
`define DROOP_CYCLES ((`DROOP_LIMIT_US * 1000) / `CLK_PERIOD_NS)

`endif

// ---- test/touch_adc_pen_irq_sequencer_tb.sv ----
`timescale 1ns/1ps
module touch_adc_pen_irq_sequencer_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbAdr = 4'h0;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatI = 32'h0;
    logic xPlusSense = 1'b1;
    wire [31:0] wbDatO;
    wire wbAck, csN, serial_bit_clock, serialIn, serialOut, serialOutEn, busy, busyEn;
    wire pen_touch_irq_n, xPlusPullupEn, yLowDriverOn, adcPowered, refPowered;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [11:0] smp, got, got2;
    logic [7:0] cb, cb2;

    always #5 sys_clk = ~sys_clk;

    touch_adc_pen_irq_sequencer dut_u (.sys_clk(sys_clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .csN(csN), .serial_bit_clock(serial_bit_clock), .serialIn(serialIn), .xPlusSense(xPlusSense),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .busy(busy), .busyEn(busyEn),
        .pen_touch_irq_n(pen_touch_irq_n), .xPlusPullupEn(xPlusPullupEn), .yLowDriverOn(yLowDriverOn),
        .adcPowered(adcPowered), .refPowered(refPowered));
    touch_host_model host_u (.csN(csN), .serial_bit_clock(serial_bit_clock), .serialIn(serialIn),
        .serialOut(serialOut));

    function automatic logic [11:0] exp_word(logic [11:0] s, logic m);
        return m ? {s[11:4], 4'h0} : s;
    endfunction

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= d;
        do @(posedge sys_clk); while (wbAck !== 1'b1 && ++n < 20);
        q = wbDatO;
        if (n >= 20) mismatches++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
        end
    endtask

    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        final_report();
    end

    initial begin
        void'($urandom(59));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        wb(1'b0, 4'h2, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b1, 4'hC, 32'h0, rd);
        for (int k = 0; k < 10; k++) begin
            smp = $urandom;
            cb = $urandom;
            cb[7] = 1'b1;
            if (k < 4) cb[3] = k[0]; // corner: both resolutions, both auto power choices
            if (k < 4) cb[0] = k[1];
            wb(1'b1, 4'h0, {20'h0, smp}, rd);
            host_u.frame(cb, got);
            chk({20'h0, got}, {20'h0, exp_word(smp, cb[3])});
            wb(1'b0, 4'h4, 32'h0, rd);
            chk(rd, {24'h0, cb});
            wb(1'b0, 4'hC, 32'h0, rd);
            chk(rd, k + 1);
            wb(1'b0, 4'h8, 32'h0, rd);
            chk({31'h0, rd[4]}, {31'h0, cb[1]});
            chk({31'h0, rd[3]}, 32'h0);
            chk({31'h0, adcPowered}, 32'h0);
            chk({31'h0, serialOutEn}, 32'h0);
            chk({31'h0, busy}, 32'h0);
            chk({31'h0, xPlusPullupEn}, {31'h0, ~cb[0]});
            chk({31'h0, yLowDriverOn}, {31'h0, ~cb[0]});
            // touched screen shows only while detection is enabled
            xPlusSense <= 1'b0;
            repeat (10) @(posedge sys_clk);
            chk({31'h0, pen_touch_irq_n}, {31'h0, cb[0]});
            xPlusSense <= 1'b1;
            repeat (10) @(posedge sys_clk);
            $display("test %0d done", k);
        end
        // overlapped bytes at the fastest spacing
        smp = $urandom;
        cb = $urandom;
        cb[7] = 1'b1;
        cb2 = $urandom;
        cb2[7] = 1'b1;
        wb(1'b1, 4'h0, {20'h0, smp}, rd);
        host_u.pair(cb, cb2, got, got2);
        chk({20'h0, got}, {20'h0, exp_word(smp, cb[3])});
        chk({20'h0, got2}, {20'h0, exp_word(smp, cb2[3])});
        wb(1'b0, 4'hC, 32'h0, rd);
        chk(rd, 32'h0000000C);
        $display("test overlap done");
        final_report();
    end
endmodule // touch_adc_pen_irq_sequencer_tb

// ---- test/touch_host_model.sv ----
`timescale 1ns/1ps
module touch_host_model (
    output logic csN,
    output logic serial_bit_clock,
    output logic serialIn,
    input wire serialOut
);
    initial begin
        csN = 1'b1;
        serial_bit_clock = 1'b0;
        serialIn = 1'b0;
    end
    // bit clock stands low outside frames; 24 clocks give one whole result
    task automatic frame(input logic [7:0] cb, output logic [11:0] got);
        logic [23:0] tx;
        tx = {cb, 16'h0000};
        got = 12'h000;
        csN = 1'b0;
        #200;
        for (int i = 0; i < 24; i++) begin
            serialIn = tx[23 - i];
            #62.5 serial_bit_clock = 1'b1;
            if (i >= 9 && i <= 20) got = {got[10:0], serialOut};
            #62.5 serial_bit_clock = 1'b0;
        end
        #200 csN = 1'b1;
        #300;
    endtask
    // two bytes 15 clocks apart: the second overlaps the first result
    task automatic pair(input logic [7:0] cb, input logic [7:0] cb2, output logic [11:0] got,
        output logic [11:0] got2);
        logic [38:0] tx;
        tx = {cb, 7'h00, cb2, 16'h0000};
        got = 12'h000;
        got2 = 12'h000;
        csN = 1'b0;
        #200;
        for (int i = 0; i < 39; i++) begin
            serialIn = tx[38 - i];
            #62.5 serial_bit_clock = 1'b1;
            if (i >= 9 && i <= 20) got = {got[10:0], serialOut};
            if (i >= 24 && i <= 35) got2 = {got2[10:0], serialOut};
            #62.5 serial_bit_clock = 1'b0;
        end
        #200 csN = 1'b1;
        #300;
    endtask
endmodule // touch_host_model

// ---- test/touch_seq_monitor.sv ----
`timescale 1ns/1ps
module touch_seq_monitor (
    input wire sys_clk,
    input wire reset,
    input wire wbCyc,
    input wire wbStb,
    input wire [31:0] wbDatO,
    input wire wbAck,
    input wire serialOut,
    input wire serialOutEn,
    input wire busy,
    input wire busyEn,
    input wire pen_touch_irq_n,
    input wire xPlusPullupEn,
    input wire yLowDriverOn,
    input wire adcPowered,
    input wire refPowered
);
    default clocking mcb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_ACK_LAT: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("ack late");
    AST_ACK_ONE: assert property (wbAck |=> !wbAck) else $error("ack too long");
    AST_DAT_IDLE: assert property (!wbAck |-> wbDatO == 32'h0) else $error("data outside ack");
    AST_PULL_IRQ: assert property (busy && $past(busy) |-> !xPlusPullupEn)
        else $error("pull-up on during measurement");
    AST_Y_SLEEP: assert property (yLowDriverOn |-> !adcPowered) else $error("y driver while powered");
    AST_OUT_OFF: assert property (!serialOutEn && !$past(serialOutEn) |-> !serialOut)
        else $error("output while deselected");
    AST_EN_PAIR: assert property (busyEn == serialOutEn) else $error("enables differ");
    AST_BUSY_POW: assert property (busy |-> adcPowered) else $error("busy unpowered");
    AST_BUSY_LEN: assert property ($rose(busy) |=> busy [*8] ##[1:8] !busy)
        else $error("busy width");
    AST_REF_KEEP: assert property ($fell(serialOutEn) |-> refPowered == $past(refPowered))
        else $error("reference dropped at deselect");
endmodule // touch_seq_monitor

bind touch_adc_pen_irq_sequencer touch_seq_monitor mon_u (.sys_clk(sys_clk), .reset(reset),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbDatO(wbDatO), .wbAck(wbAck), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .busy(busy), .busyEn(busyEn), .pen_touch_irq_n(pen_touch_irq_n),
    .xPlusPullupEn(xPlusPullupEn), .yLowDriverOn(yLowDriverOn), .adcPowered(adcPowered),
    .refPowered(refPowered));

// ---- verilog/result_shifter.v ----
`timescale 1ns/1ps
module result_shifter #(
    parameter W = 12
) (
    input wire sys_clk,
    input wire reset,
    input wire clear,
    input wire load,
    input wire [W-1:0] loadWord,
    input wire shift,
    output reg bitOut
);
    reg [W-1:0] shiftReg;

    always @(posedge sys_clk) begin
        if (reset || clear) begin
            shiftReg <= {W{1'b0}};
            bitOut <= 1'b0;
        end else if (load) begin
            shiftReg <= loadWord;
            bitOut <= 1'b0;
        end else if (shift) begin
            // msb first, zeros fill once the word is out
            bitOut <= shiftReg[W-1];
            shiftReg <= {shiftReg[W-2:0], 1'b0};
        end
    end
endmodule // result_shifter

// ---- verilog/sync_bits.v ----
`timescale 1ns/1ps
module sync_bits #(
    parameter W = 4
) (
    input wire sys_clk,
    input wire reset,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] synced
);
    reg [W-1:0] stage;

    always @(posedge sys_clk) begin
        if (reset) begin
            stage <= {W{1'b0}};
            synced <= {W{1'b0}};
        end else begin
            stage <= asyncIn;
            synced <= stage;
        end
    end
endmodule // sync_bits

// ---- verilog/touch_adc_pen_irq_sequencer.v ----
// Operation
// - power-down with auto bit clear grounds Y
// - pen output reaches X-plus through gates, pull-up
// - touch pulls X-plus low, irq goes low
// - X/Y/Z measurement disconnects X-plus pull-up
// - X/Y/Z measurement holds irq low
// - battery/aux/temperature measurement holds irq high
// - auto bit set keeps pen detection off
// - auto bit clear re-enables detection at end
// - conversion ends on fall after bit one
// - overlapped control bytes, conversion every 16 clocks
// - stay powered while conversion in progress
// - support a control byte every 15 clocks
// - results unsigned straight binary, msb first
// - 8-bit mode ends four clocks earlier
// - first high bit starts a control byte
// - mode bit low 12-bit, high 8-bit
// - both power bits zero: sleep between conversions
// - chip select high aborts, reference stays
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "touch_seq_map.vh"
module touch_adc_pen_irq_sequencer #(
    parameter DROOP_CYCLES = `DROOP_CYCLES
) (
    input wire sys_clk,
    input wire reset,
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [3:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatI,
    output reg [31:0] wbDatO,
    output reg wbAck,
    input wire csN,
    input wire serial_bit_clock,
    input wire serialIn,
    input wire xPlusSense,
    output wire serialOut,
    output reg serialOutEn,
    output reg busy,
    output reg busyEn,
    output reg pen_touch_irq_n,
    output reg xPlusPullupEn,
    output reg yLowDriverOn,
    output reg adcPowered,
    output reg refPowered
);
    // pin synchronisers
    wire [3:0] pinSync;
    wire csNSync;
    wire clkSync;
    wire dinSync;
    wire xPlusSync;

    sync_bits #(.W(4)) pinSyncInst (
        .sys_clk(sys_clk),
        .reset(reset),
        .asyncIn({~xPlusSense, serialIn, serial_bit_clock, ~csN}),
        .synced(pinSync)
    );
    // high-idle pins go through inverted so the flushed synchroniser reads idle, not selected or touched
    assign csNSync = ~pinSync[0];
    assign clkSync = pinSync[1];
    assign dinSync = pinSync[2];
    assign xPlusSync = ~pinSync[3];

    reg clkPrev;
    wire clkRise;
    wire clkFall;

    always @(posedge sys_clk) begin
        if (reset) begin
            clkPrev <= 1'b0;
        end else begin
            clkPrev <= clkSync;
        end
    end

    // edges only count while selected; a deselected host may toggle freely
    assign clkRise = clkSync & ~clkPrev & ~csNSync;
    assign clkFall = ~clkSync & clkPrev & ~csNSync;

    // software registers
    reg [11:0] sampleWord;
    reg [7:0] ctrlByte;
    reg [15:0] convCount;
    reg droopFlag;

    // control byte receiver
    reg rxActive;
    reg [2:0] rxCount;
    reg [6:0] rxShift;
    reg ctrlPending;
    reg [7:0] pendingByte;

    // active conversion
    reg measuring;
    reg [4:0] shiftsDone;
    reg [2:0] chan;
    reg eightBit;
    reg lastPd0;
    reg penEnabled;
    reg [17:0] droopCount;

    wire startConv;
    wire midConv;
    wire endConv;
    wire [4:0] convBits;
    wire touchMeas;
    wire [11:0] loadWord;
    wire wbReq;
    wire wbWrite;
    wire [31:0] statusWord;

    assign startConv = clkFall & ctrlPending;
    assign midConv = clkFall & ~ctrlPending & measuring;
    assign convBits = eightBit ? `BITS_8 : `BITS_12;
    // the shift that puts bit 0 out is the fall after bit 1
    assign endConv = midConv & (shiftsDone + 5'h01 == convBits);

    assign touchMeas = (chan == `CHAN_X) | (chan == `CHAN_Y) | (chan == `CHAN_Z1) | (chan == `CHAN_Z2);

    // 8-bit results use the top of the sample word, still msb first
    assign loadWord = pendingByte[`CB_MODE] ? {sampleWord[11:4], 4'h0} : sampleWord;

    result_shifter #(.W(12)) outShifter (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(csNSync),
        .load(startConv),
        .loadWord(loadWord),
        .shift(clkFall & ~ctrlPending),
        .bitOut(serialOut)
    );

    // receiver runs independently of the conversion so bytes may overlap
    always @(posedge sys_clk) begin
        if (reset) begin
            rxActive <= 1'b0;
            rxCount <= 3'h0;
            rxShift <= 7'h00;
            ctrlPending <= 1'b0;
            pendingByte <= `CTRL_BYTE_RESET;
            ctrlByte <= `CTRL_BYTE_RESET;
        end else if (csNSync) begin
            rxActive <= 1'b0;
            rxCount <= 3'h0;
            ctrlPending <= 1'b0;
        end else begin
            if (clkRise) begin
                if (!rxActive) begin
                    if (dinSync) begin
                        rxActive <= 1'b1;
                        rxCount <= 3'h1;
                        rxShift <= 7'h01;
                    end
                end else begin
                    rxShift <= {rxShift[5:0], dinSync};
                    rxCount <= rxCount + 3'h1;
                    if (rxCount == 3'h7) begin
                        rxActive <= 1'b0;
                        pendingByte <= {rxShift, dinSync};
                        ctrlByte <= {rxShift, dinSync};
                        ctrlPending <= 1'b1;
                    end
                end
            end
            if (startConv) begin
                ctrlPending <= 1'b0;
            end
        end
    end

    // conversion sequencing and power
    always @(posedge sys_clk) begin
        if (reset) begin
            measuring <= 1'b0;
            busy <= 1'b0;
            shiftsDone <= 5'h00;
            chan <= 3'h0;
            eightBit <= 1'b0;
            lastPd0 <= 1'b0;
            penEnabled <= 1'b1;
            adcPowered <= 1'b0;
            refPowered <= 1'b0;
        end else if (csNSync) begin
            // abandoned mid-way; the reference keeps its latched state
            measuring <= 1'b0;
            busy <= 1'b0;
            shiftsDone <= 5'h00;
            adcPowered <= 1'b0;
            penEnabled <= ~lastPd0;
        end else if (startConv) begin
            // a new byte preempts whatever is left of the old result
            measuring <= 1'b1;
            busy <= 1'b1;
            shiftsDone <= 5'h00;
            chan <= pendingByte[`CB_CHAN_HI:`CB_CHAN_LO];
            eightBit <= pendingByte[`CB_MODE];
            lastPd0 <= pendingByte[`CB_PD0];
            penEnabled <= 1'b0;
            adcPowered <= 1'b1;
            refPowered <= pendingByte[`CB_PD1];
        end else if (midConv) begin
            busy <= 1'b0;
            shiftsDone <= shiftsDone + 5'h01;
            if (endConv) begin
                measuring <= 1'b0;
                penEnabled <= ~lastPd0;
                adcPowered <= lastPd0;
            end
        end else if (measuring) begin
            adcPowered <= 1'b1;
        end
    end

    // pen path: the x-plus sense reaches the irq only through the gated path
    always @(posedge sys_clk) begin
        if (reset) begin
            pen_touch_irq_n <= 1'b1;
            xPlusPullupEn <= 1'b0;
            yLowDriverOn <= 1'b0;
        end else begin
            if (measuring) begin
                pen_touch_irq_n <= ~touchMeas;
            end else if (penEnabled) begin
                pen_touch_irq_n <= xPlusSync;
            end else begin
                pen_touch_irq_n <= 1'b1;
            end
            xPlusPullupEn <= penEnabled & ~(measuring & touchMeas);
            // released in the very cycle the converter powers up, never overlapping it
            yLowDriverOn <= ~adcPowered & ~lastPd0 & ~measuring & ~startConv;
        end
    end

    // output enables follow chip select
    always @(posedge sys_clk) begin
        if (reset) begin
            serialOutEn <= 1'b0;
            busyEn <= 1'b0;
        end else begin
            serialOutEn <= ~csNSync;
            busyEn <= ~csNSync;
        end
    end

    // droop watch: flags a conversion that outlived the hold time
    always @(posedge sys_clk) begin
        if (reset) begin
            droopCount <= 18'h00000;
            droopFlag <= 1'b0;
        end else if (startConv) begin
            droopCount <= 18'h00000;
            droopFlag <= 1'b0;
        end else if (measuring) begin
            if (droopCount == DROOP_CYCLES[17:0]) begin
                droopFlag <= 1'b1;
            end else begin
                droopCount <= droopCount + 18'h00001;
            end
        end
    end

    // wishbone slave, one wait state, ack for one cycle
    assign wbReq = wbCyc & wbStb & ~wbAck;
    assign wbWrite = wbReq & wbWe;

    assign statusWord = {22'h000000, csNSync, rxActive, droopFlag, pen_touch_irq_n,
        yLowDriverOn, refPowered, adcPowered, penEnabled, measuring, busy};

    always @(posedge sys_clk) begin
        if (reset) begin
            sampleWord <= `SAMPLE_RESET;
        end else if (wbWrite && wbAdr == `REG_SAMPLE) begin
            if (wbSel[0]) begin
                sampleWord[7:0] <= wbDatI[7:0];
            end
            if (wbSel[1]) begin
                sampleWord[11:8] <= wbDatI[11:8];
            end
        end
    end

    // a completion in the write cycle still counts
    always @(posedge sys_clk) begin
        if (reset) begin
            convCount <= 16'h0000;
        end else if (wbWrite && wbAdr == `REG_CONV_COUNT) begin
            convCount <= endConv ? 16'h0001 : 16'h0000;
        end else if (endConv) begin
            convCount <= convCount + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            wbAck <= 1'b0;
            wbDatO <= 32'h00000000;
        end else begin
            wbAck <= wbReq;
            if (wbReq && !wbWe) begin
                case (wbAdr)
                    `REG_SAMPLE: wbDatO <= {20'h00000, sampleWord};
                    `REG_CTRL_BYTE: wbDatO <= {24'h000000, ctrlByte};
                    `REG_STATUS: wbDatO <= statusWord;
                    `REG_CONV_COUNT: wbDatO <= {16'h0000, convCount};
                    default: wbDatO <= 32'h00000000;
                endcase
            end else begin
                wbDatO <= 32'h00000000;
            end
        end
    end
endmodule // touch_adc_pen_irq_sequencer
